// >>> rtl/sacr_consts.svh
// Register offsets, field positions, reset values and timing counts of the
// spectral converter configuration bank.
// Assumes inclusion by the design modules; the package does not include it.
`ifndef SACR_CONSTS_SVH
`define SACR_CONSTS_SVH
`define SACR_ADDR_AUX_IDENT 8'h90
`define SACR_ADDR_REV_IDENT 8'h91
`define SACR_ADDR_PART_IDENT 8'h92
`define SACR_ADDR_FIFO_GAIN_CTRL 8'hB1
`define SACR_ADDR_GAIN_CEILING 8'hCF
`define SACR_ADDR_AUTOZERO_CFG 8'hD6
`define SACR_ADDR_IRQ_STATUS 8'hE0
`define SACR_ADDR_IRQ_MASK 8'hE1
`define SACR_ADDR_GAIN_STATE 8'hE2
`define SACR_RST_AUTOZERO 8'hFF
`define SACR_RST_GAIN_CEILING 8'h99
`define SACR_RST_FIFO_GAIN_CTRL 8'h88
`define SACR_RST_IRQ_MASK 8'h00
`define SACR_FIFO_TRIG_MSB 7
`define SACR_FIFO_TRIG_LSB 6
`define SACR_FLK_AGC_BIT 3
`define SACR_SPECTRAL_AUTO_GAIN_EN_BIT 2
`define SACR_FIFO_GAIN_WMASK 8'hCC
`define SACR_CEIL_FLK_MSB 7
`define SACR_CEIL_FLK_LSB 4
`define SACR_CEIL_SP_MSB 3
`define SACR_CEIL_SP_LSB 0
`define SACR_GAIN_CODE_MAX 4'hA
`define SACR_AZ_NEVER 8'h00
`define SACR_AZ_ONCE 8'hFF
`define SACR_AZ_TIME_US 15000
`define SACR_CLK_MHZ 50
`define SACR_AZ_CYCLES (`SACR_AZ_TIME_US * `SACR_CLK_MHZ)
`endif

// >>> rtl/sacr_pkg.sv
// Types shared by the configuration bank and its auto-zero sequencer.
// Assumes the constants header sits beside it.
package sacr_pkg;
  typedef enum logic [3:0] {
    SACR_AZ_IDLE = 4'b0001,
    SACR_AZ_RUN = 4'b0010,
    SACR_AZ_MEAS = 4'b0100,
    SACR_AZ_DONE = 4'b1000
  } sacr_az_state_t;
  typedef logic [3:0] sacr_gain_t;
endpackage : sacr_pkg

// >>> rtl/sacr_autozero_seq.sv
// Auto-zero sequencer: decides before which integration cycle the
// converter offsets are zeroed and holds off measurement while it runs.
// Assumes cycle_start_i is a one-cycle pulse from logic on clk_sys_i.
`include "sacr_consts.svh"
module sacr_autozero_seq #(
  parameter int unsigned AZ_CYCLES = `SACR_AZ_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Control
  input wire logic [7:0] interval_i,
  input wire logic flicker_en_i,
  input wire logic cycle_start_i,
  // Status
  output logic az_busy_o,
  output logic az_flicker_o,
  output logic az_done_o
);
  import sacr_pkg::*;
  sacr_az_state_t state;
  logic [7:0] cyc_cnt;
  logic first_done;
  logic [31:0] az_cnt;
  logic az_due;

  // Unless disabled, due when first ever, or outside once mode when the count of cycles reaches the interval
  always_comb begin
    if (interval_i == `SACR_AZ_NEVER) begin
      az_due = 1'b0;
    end else if (interval_i == `SACR_AZ_ONCE) begin
      az_due = !first_done;
    end else begin
      az_due = !first_done || (cyc_cnt + 8'h01 >= interval_i);
    end
  end

  // Sequencer state and duration counter
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= SACR_AZ_IDLE;
      az_cnt <= 32'h0000_0000;
      cyc_cnt <= 8'h00;
      first_done <= 1'b0;
      az_flicker_o <= 1'b0;
    end else if (clk_en_i) begin
      case (state)
        SACR_AZ_IDLE, SACR_AZ_MEAS, SACR_AZ_DONE: begin
          if (cycle_start_i && az_due) begin
            state <= SACR_AZ_RUN;
            az_cnt <= AZ_CYCLES - 1;
            az_flicker_o <= flicker_en_i;
            cyc_cnt <= 8'h00;
          end else if (cycle_start_i) begin
            state <= SACR_AZ_MEAS;
            cyc_cnt <= cyc_cnt + 8'h01;
          end else if (state == SACR_AZ_DONE) begin
            state <= SACR_AZ_MEAS;
          end
        end
        SACR_AZ_RUN: begin
          if (az_cnt == 32'h0000_0000) begin
            state <= SACR_AZ_DONE;
            first_done <= 1'b1;
            az_flicker_o <= 1'b0;
          end else begin
            az_cnt <= az_cnt - 32'h0000_0001;
          end
        end
        default: state <= SACR_AZ_IDLE;
      endcase
    end
  end

  assign az_busy_o = (state == SACR_AZ_RUN);
  assign az_done_o = (state == SACR_AZ_DONE);

  a_az_disabled: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (interval_i == `SACR_AZ_NEVER && state != SACR_AZ_RUN) |=> !az_busy_o)
    else $error("auto-zero started while disabled");
  a_az_once_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (first_done && interval_i == `SACR_AZ_ONCE && state != SACR_AZ_RUN) |=> !az_busy_o)
    else $error("auto-zero repeated in once mode");
  a_az_min_time: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(az_busy_o) && clk_en_i |=> az_busy_o)
    else $error("auto-zero ended too early");
endmodule : sacr_autozero_seq

// >>> rtl/sacr_config_regs.sv
// Configuration and identification register bank of a multi-channel
// spectral sensor: auto-zero interval, gain ceilings, FIFO trigger level,
// automatic gain enables and read-only identity fields, plus the
// automatic gain stepping that those settings steer.
// Assumes a single-cycle strobe bus master on clk_sys_i and that the
// FIFO level, conversion data and cycle strobes come from the same clock.
//
// Operation
// - Auto-zero every N integration cycles for N 1..254; zero disables it.
// - Interval value 255 auto-zeros once before the first measurement only.
// - Each auto-zero lasts about 15 ms; measurement waits for it.
// - With flicker enabled, converter 5 is zeroed and flicker measure paused.
// - Flicker gain ceiling in bits 7:4, reset 9, codes 0..10.
// - Spectral gain ceiling in bits 3:0, reset 9, codes 0..10.
// - FIFO trigger code 0..3 selects 1,4,8,16 entries; reset 2.
// - Flicker automatic gain enable bit 3, reset 1, steers flicker gain.
// - Spectral automatic gain enable bit 2, reset 0, steers spectral gain.
// - Aux ident bits 3:0, revision bits 2:0, part ident bits 7:2.
// - Identification fields are read-only; writes leave them unchanged.
// - Gain codes are powers of two, 0 is 0.5x up to 10 is 512x.
// - Spectral gain drops when data exceeds the high share of full scale.
// - Spectral gain rises below the low share, never above the ceiling.
//
// Strobed register access was chosen for this implementation.
`include "sacr_consts.svh"
module sacr_config_regs #(
  parameter int unsigned AZ_CYCLES = `SACR_AZ_CYCLES,
  parameter logic [3:0] AUX_IDENT = 4'h1, // Arbitrary value
  parameter logic [2:0] REV_IDENT = 3'h2, // Arbitrary value
  parameter logic [5:0] PART_IDENT = 6'h15 // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Measurement engine
  input wire logic cycle_start_i,
  input wire logic cycle_end_i,
  input wire logic [15:0] sp_data_i,
  input wire logic [7:0] integration_step_count_i,
  input wire logic [15:0] integration_step_size_i,
  input wire logic [1:0] gain_down_threshold_i,
  input wire logic [1:0] gain_up_threshold_i,
  input wire logic flicker_en_i,
  input wire logic flicker_low_i,
  input wire logic flicker_sat_i,
  input wire logic [4:0] fifo_level_i,
  // Controls to the engines
  output logic [3:0] spectral_gain_code_o,
  output logic [3:0] flicker_gain_code_o,
  output logic az_busy_o,
  output logic az_flicker_o,
  output logic flicker_pause_o,
  output logic fifo_irq_o,
  // Interrupt
  output logic irq_o
);
  import sacr_pkg::*;

  logic [7:0] autozero_config;
  logic [7:0] gain_ceiling;
  logic [7:0] fifo_and_gain_control;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] next_rdata;
  logic [24:0] full_scale;
  logic [24:0] hi_level;
  logic [24:0] lo_level;
  logic [4:0] fifo_need;
  logic az_done;
  logic gain_dn_evt;
  logic gain_up_evt;
  logic [7:0] evt;

  // Fixed point share of full scale, in eighths
  function automatic logic [24:0] eighths(input logic [24:0] fs, input logic [3:0] n);
    logic [28:0] p;
    p = fs * n;
    eighths = p[27:3];
  endfunction : eighths

  // Clamp a gain code to the supported range
  function automatic sacr_gain_t clamp_code(input logic [3:0] c);
    clamp_code = (c > `SACR_GAIN_CODE_MAX) ? `SACR_GAIN_CODE_MAX : c;
  endfunction : clamp_code

  // Writable configuration registers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      autozero_config <= `SACR_RST_AUTOZERO;
      gain_ceiling <= `SACR_RST_GAIN_CEILING;
      fifo_and_gain_control <= `SACR_RST_FIFO_GAIN_CTRL;
      irq_mask <= `SACR_RST_IRQ_MASK;
    end else if (clk_en_i && reg_wr_i) begin
      case (reg_addr_i)
        `SACR_ADDR_AUTOZERO_CFG: autozero_config <= reg_wdata_i;
        `SACR_ADDR_GAIN_CEILING: begin
          gain_ceiling[`SACR_CEIL_FLK_MSB:`SACR_CEIL_FLK_LSB] <=
            clamp_code(reg_wdata_i[7:4]);
          gain_ceiling[`SACR_CEIL_SP_MSB:`SACR_CEIL_SP_LSB] <=
            clamp_code(reg_wdata_i[3:0]);
        end
        `SACR_ADDR_FIFO_GAIN_CTRL:
          fifo_and_gain_control <= reg_wdata_i & `SACR_FIFO_GAIN_WMASK;
        `SACR_ADDR_IRQ_MASK: irq_mask <= {5'h00, reg_wdata_i[2:0]};
        default: ; // Identity and unmapped addresses ignore writes
      endcase
    end
  end

  // Read mux; identity fields are constants
  always_comb begin
    case (reg_addr_i)
      `SACR_ADDR_AUX_IDENT: next_rdata = {4'h0, AUX_IDENT};
      `SACR_ADDR_REV_IDENT: next_rdata = {5'h00, REV_IDENT};
      `SACR_ADDR_PART_IDENT: next_rdata = {PART_IDENT, 2'h0};
      `SACR_ADDR_FIFO_GAIN_CTRL: next_rdata = fifo_and_gain_control;
      `SACR_ADDR_GAIN_CEILING: next_rdata = gain_ceiling;
      `SACR_ADDR_AUTOZERO_CFG: next_rdata = autozero_config;
      `SACR_ADDR_IRQ_STATUS: next_rdata = irq_status;
      `SACR_ADDR_IRQ_MASK: next_rdata = irq_mask;
      `SACR_ADDR_GAIN_STATE: next_rdata = {flicker_gain_code_o, spectral_gain_code_o};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
    end
  end

  // Auto-zero sequencer
  sacr_autozero_seq #(
    .AZ_CYCLES(AZ_CYCLES)
  ) u_az (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .interval_i(autozero_config),
    .flicker_en_i(flicker_en_i),
    .cycle_start_i(cycle_start_i),
    .az_busy_o(az_busy_o),
    .az_flicker_o(az_flicker_o),
    .az_done_o(az_done)
  );

  // Flicker measurement held off while converter 5 is zeroed
  assign flicker_pause_o = az_flicker_o;

  // FIFO level trigger, 1 / 4 / 8 / 16 entries
  always_comb begin
    case (fifo_and_gain_control[`SACR_FIFO_TRIG_MSB:`SACR_FIFO_TRIG_LSB])
      2'd0: fifo_need = 5'd1;
      2'd1: fifo_need = 5'd4;
      2'd2: fifo_need = 5'd8;
      default: fifo_need = 5'd16;
    endcase
  end
  assign fifo_irq_o = (fifo_level_i >= fifo_need);

  // Thresholds as shares of full scale (steps+1)*(size+1); 25 bits hold 256 x 65536
  assign full_scale = (25'(integration_step_count_i) + 25'd1) *
                      (25'(integration_step_size_i) + 25'd1);
  assign hi_level = eighths(full_scale, {2'b01, gain_down_threshold_i});
  // Low share steps by one eighth: 12.5, 25, 37.5, 50 percent
  assign lo_level = eighths(full_scale, {2'b00, gain_up_threshold_i} + 4'h1);

  assign gain_dn_evt = cycle_end_i && fifo_and_gain_control[`SACR_SPECTRAL_AUTO_GAIN_EN_BIT] &&
                       (25'(sp_data_i) > hi_level) && (spectral_gain_code_o != 4'h0);
  assign gain_up_evt = cycle_end_i && fifo_and_gain_control[`SACR_SPECTRAL_AUTO_GAIN_EN_BIT] &&
                       (25'(sp_data_i) < lo_level) &&
                       (spectral_gain_code_o < gain_ceiling[3:0]);

  // Spectral gain stepping, one power of two per cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      spectral_gain_code_o <= 4'h9; // 256x, code powers of two
    end else if (clk_en_i) begin
      if (spectral_gain_code_o > gain_ceiling[3:0]) begin
        spectral_gain_code_o <= gain_ceiling[3:0];
      end else if (gain_dn_evt) begin
        spectral_gain_code_o <= spectral_gain_code_o - 4'h1;
      end else if (gain_up_evt) begin
        spectral_gain_code_o <= spectral_gain_code_o + 4'h1;
      end
    end
  end

  // Flicker gain stepping
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flicker_gain_code_o <= 4'h9;
    end else if (clk_en_i) begin
      if (flicker_gain_code_o > gain_ceiling[7:4]) begin
        flicker_gain_code_o <= gain_ceiling[7:4];
      end else if (fifo_and_gain_control[`SACR_FLK_AGC_BIT] && !az_flicker_o) begin
        if (flicker_sat_i && flicker_gain_code_o != 4'h0) begin
          flicker_gain_code_o <= flicker_gain_code_o - 4'h1;
        end else if (flicker_low_i && flicker_gain_code_o < gain_ceiling[7:4]) begin
          flicker_gain_code_o <= flicker_gain_code_o + 4'h1;
        end
      end
    end
  end

  // Sticky events: 0 auto-zero done, 1 FIFO level, 2 spectral gain stepped
  assign evt = {5'h00, gain_dn_evt | gain_up_evt, fifo_irq_o, az_done};
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status <= 8'h00;
    end else if (clk_en_i) begin
      if (reg_rd_i && reg_addr_i == `SACR_ADDR_IRQ_STATUS) begin
        irq_status <= evt; // Set wins over clear-on-read
      end else begin
        irq_status <= irq_status | evt;
      end
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  a_ident_const: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    reg_rd_i && clk_en_i && reg_addr_i == `SACR_ADDR_PART_IDENT
    |=> reg_rdata_o == {PART_IDENT, 2'h0})
    else $error("part ident read wrong");
  a_ceil_sp: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    gain_ceiling[3:0] <= `SACR_GAIN_CODE_MAX)
    else $error("spectral ceiling out of range");
  a_ceil_flk: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    gain_ceiling[7:4] <= `SACR_GAIN_CODE_MAX)
    else $error("flicker ceiling out of range");
  a_fifo_trig: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (fifo_and_gain_control[7:6] == 2'd3 && fifo_level_i == 5'd15) |-> !fifo_irq_o)
    else $error("fifo trigger too early");
  a_spectral_auto_gain_en_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!fifo_and_gain_control[2] && clk_en_i &&
     spectral_gain_code_o <= gain_ceiling[3:0] && !reg_wr_i)
    |=> $stable(spectral_gain_code_o))
    else $error("spectral gain moved while control off");
  a_gain_down: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    gain_dn_evt && clk_en_i && spectral_gain_code_o <= gain_ceiling[3:0]
    |=> spectral_gain_code_o == $past(spectral_gain_code_o) - 4'h1)
    else $error("gain not reduced");
  a_gain_cap: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    gain_up_evt |-> spectral_gain_code_o < gain_ceiling[3:0])
    else $error("gain raised past ceiling");
  a_flk_pause: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    az_busy_o && az_flicker_o |-> flicker_pause_o)
    else $error("flicker not paused");

  // Read data returns to zero when no read was strobed
  a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !reg_rd_i && clk_en_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");

  // Auxiliary identity reads its constant
  a_ident_aux: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    reg_rd_i && clk_en_i && reg_addr_i == `SACR_ADDR_AUX_IDENT
    |=> reg_rdata_o == {4'h0, AUX_IDENT})
    else $error("aux ident read wrong");

  // Control write keeps only the defined bits
  a_ctl_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    reg_wr_i && clk_en_i && reg_addr_i == `SACR_ADDR_FIFO_GAIN_CTRL
    |=> fifo_and_gain_control == ($past(reg_wdata_i) & `SACR_FIFO_GAIN_WMASK))
    else $error("control write wrong");

  // Interval write lands whole
  a_az_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    reg_wr_i && clk_en_i && reg_addr_i == `SACR_ADDR_AUTOZERO_CFG
    |=> autozero_config == $past(reg_wdata_i))
    else $error("interval write lost");

  // Trigger code 0 fires on one entry
  a_fifo_one: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (fifo_and_gain_control[7:6] == 2'd0 && fifo_level_i != 5'd0) |-> fifo_irq_o)
    else $error("fifo trigger missed");

  // Trigger code 2 waits for eight entries
  a_fifo_eight: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (fifo_and_gain_control[7:6] == 2'd2 && fifo_level_i < 5'd8) |-> !fifo_irq_o)
    else $error("fifo trigger early");

  // Raise steps by exactly one code
  a_gain_up: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    gain_up_evt && clk_en_i && spectral_gain_code_o <= gain_ceiling[3:0]
    |=> spectral_gain_code_o == $past(spectral_gain_code_o) + 4'h1)
    else $error("gain not raised");

  // Spectral gain above its ceiling is pulled to it
  a_sp_pull: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    clk_en_i && spectral_gain_code_o > gain_ceiling[3:0]
    |=> spectral_gain_code_o == $past(gain_ceiling[3:0]))
    else $error("spectral gain above ceiling");

  // Flicker gain above its ceiling is pulled to it
  a_flk_pull: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    clk_en_i && flicker_gain_code_o > gain_ceiling[7:4]
    |=> flicker_gain_code_o == $past(gain_ceiling[7:4]))
    else $error("flicker gain above ceiling");

  // Flicker gain frozen while converter 5 is zeroed
  a_flk_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    az_flicker_o && clk_en_i && flicker_gain_code_o <= gain_ceiling[7:4]
    |=> $stable(flicker_gain_code_o))
    else $error("flicker gain moved during auto-zero");

  // Flicker gain still when its control is off
  a_flk_agc_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !fifo_and_gain_control[3] && clk_en_i && flicker_gain_code_o <= gain_ceiling[7:4]
    |=> $stable(flicker_gain_code_o))
    else $error("flicker gain moved while control off");

  // Auto-zero completion is recorded
  a_status_az: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    az_done && clk_en_i |=> irq_status[0])
    else $error("auto-zero status lost");
  a_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (fifo_and_gain_control & ~`SACR_FIFO_GAIN_WMASK) == 8'h00)
    else $error("reserved bits set");
endmodule : sacr_config_regs

// >>> test/tb_sacr_config_regs.sv
// Self-checking bench for the spectral converter configuration bank.
// Assumes the design files under rtl/ are compiled first; one 50 MHz clock.
module tb_sacr_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned AZ_N = 8;
  localparam logic [3:0] AUX_V = 4'h5; // Arbitrary value
  localparam logic [2:0] REV_V = 3'h3; // Arbitrary value
  localparam logic [5:0] PART_V = 6'h2A; // Arbitrary value
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cycle_start_i = 1'b0;
  logic cycle_end_i = 1'b0;
  logic [15:0] sp_data_i = 16'h0000;
  logic [7:0] step_cnt = 8'h00;
  logic [15:0] step_size = 16'h0063;
  logic [1:0] down_th = 2'h3;
  logic [1:0] up_th = 2'h0;
  logic flicker_en_i = 1'b0;
  logic flicker_low_i = 1'b0;
  logic flicker_sat_i = 1'b0;
  logic [4:0] fifo_level_i = 5'h00;
  logic [7:0] reg_rdata_o;
  logic [3:0] spectral_gain_code_o;
  logic [3:0] flicker_gain_code_o;
  logic az_busy_o;
  logic az_flicker_o;
  logic flicker_pause_o;
  logic fifo_irq_o;
  logic irq_o;
  int err_count = 0;
  int samples_checked = 0;
  int cyc_count = 0;
  logic [7:0] rd_val;

  // Device under test with a short auto-zero count
  sacr_config_regs #(.AZ_CYCLES(AZ_N), .AUX_IDENT(AUX_V), .REV_IDENT(REV_V),
    .PART_IDENT(PART_V)) sacr_config_regs_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cycle_start_i(cycle_start_i),
    .cycle_end_i(cycle_end_i), .sp_data_i(sp_data_i),
    .integration_step_count_i(step_cnt), .integration_step_size_i(step_size),
    .gain_down_threshold_i(down_th), .gain_up_threshold_i(up_th),
    .flicker_en_i(flicker_en_i), .flicker_low_i(flicker_low_i), .flicker_sat_i(flicker_sat_i),
    .fifo_level_i(fifo_level_i), .spectral_gain_code_o(spectral_gain_code_o),
    .flicker_gain_code_o(flicker_gain_code_o), .az_busy_o(az_busy_o),
    .az_flicker_o(az_flicker_o), .flicker_pause_o(flicker_pause_o),
    .fifo_irq_o(fifo_irq_o), .irq_o(irq_o));

  // Clock and hang guard
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic do_reset();
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
  endtask : do_reset

  // One-cycle register strobes
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask : reg_read

  task automatic pulse(input bit is_start);
    @(posedge clk_sys_i);
    if (is_start) cycle_start_i <= 1'b1; else cycle_end_i <= 1'b1;
    @(posedge clk_sys_i);
    cycle_start_i <= 1'b0;
    cycle_end_i <= 1'b0;
  endtask : pulse

  // Starts an integration cycle and counts the auto-zero busy cycles
  task automatic az_run(output int n);
    n = 0;
    pulse(1'b1);
    #1;
    if (az_busy_o === 1'b1) chk("az_flicker", {15'h0000, az_flicker_o}, {15'h0000, flicker_en_i});
    if (az_busy_o === 1'b1) chk("flk_pause", {15'h0000, flicker_pause_o}, {15'h0000, flicker_en_i});
    repeat (20) begin
      if (az_busy_o === 1'b1) n++;
      @(posedge clk_sys_i);
      #1;
    end
  endtask : az_run

  task automatic t_reset_vals();
    chk("sp_gain_rst", spectral_gain_code_o, 16'h0009);
    chk("flk_gain_rst", flicker_gain_code_o, 16'h0009);
    reg_read(8'hD6); chk("az_cfg_rst", rd_val, 16'h00FF);
    @(posedge clk_sys_i); #1 chk("rdata_idle", reg_rdata_o, 16'h0000);
    reg_read(8'hCF); chk("ceil_rst", rd_val, 16'h0099);
    reg_read(8'hB1); chk("fifo_ctl_rst", rd_val, 16'h0088);
    reg_read(8'hE1); chk("mask_rst", rd_val, 16'h0000);
    $display("test reset values done");
  endtask : t_reset_vals

  task automatic t_ident();
    logic [7:0] exp_v [3];
    exp_v = '{{4'h0, AUX_V}, {5'h00, REV_V}, {PART_V, 2'b00}};
    for (int i = 0; i < 3; i++) begin
      reg_read(8'h90 + 8'(i)); chk("ident", rd_val, {8'h00, exp_v[i]});
      reg_write(8'h90 + 8'(i), 8'hFF);
      reg_read(8'h90 + 8'(i)); chk("ident_ro", rd_val, {8'h00, exp_v[i]});
    end
    $display("test ident done");
  endtask : t_ident

  task automatic t_rw();
    reg_write(8'hB1, 8'hFF);
    reg_read(8'hB1); chk("fifo_ctl_rsv", rd_val, 16'h00CC);
    reg_write(8'hD6, 8'h5A);
    reg_read(8'hD6); chk("az_cfg_rw", rd_val, 16'h005A);
    reg_write(8'h00, 8'hFF);
    reg_read(8'h00); chk("unmapped", rd_val, 16'h0000);
    $display("test read write done");
  endtask : t_rw

  task automatic t_fifo();
    logic [4:0] lvl [4];
    lvl = '{5'h01, 5'h04, 5'h08, 5'h10};
    for (int c = 0; c < 4; c++) begin
      reg_write(8'hB1, {2'(c), 6'h08});
      fifo_level_i <= lvl[c] - 5'h01;
      @(posedge clk_sys_i); #1 chk("fifo_below", {15'h0000, fifo_irq_o}, 16'h0000);
      fifo_level_i <= lvl[c];
      @(posedge clk_sys_i); #1 chk("fifo_at", {15'h0000, fifo_irq_o}, 16'h0001);
    end
    fifo_level_i <= 5'h00;
    $display("test fifo trigger done");
  endtask : t_fifo

  // Full scale is 1 x 100; high share 87.5 percent, low share 12.5 percent
  task automatic agc_step(input logic [15:0] d, input logic [3:0] exp);
    sp_data_i <= d;
    pulse(1'b0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("sp_gain", spectral_gain_code_o, {12'h000, exp});
  endtask : agc_step

  task automatic t_agc();
    reg_write(8'hB1, 8'h88);
    agc_step(16'h005F, 4'h9);
    reg_write(8'hB1, 8'h8C);
    agc_step(16'h005F, 4'h8);
    agc_step(16'h0032, 4'h8);
    agc_step(16'h0005, 4'h9);
    agc_step(16'h0005, 4'h9);
    $display("test gain control done");
  endtask : t_agc

  task automatic t_ceiling();
    reg_write(8'hCF, 8'h35);
    reg_read(8'hCF); chk("ceil_rw", rd_val, 16'h0035);
    chk("sp_ceil", spectral_gain_code_o, 16'h0005);
    chk("flk_ceil", flicker_gain_code_o, 16'h0003);
    reg_write(8'hCF, 8'hFF);
    reg_read(8'hCF); chk("ceil_clamp", rd_val, 16'h00AA);
    $display("test gain ceiling done");
  endtask : t_ceiling

  // Flicker gain at 3 under ceiling 10; hints step it only while enabled
  task automatic t_flicker();
    flicker_low_i <= 1'b1;
    @(posedge clk_sys_i); flicker_low_i <= 1'b0;
    @(posedge clk_sys_i); #1 chk("flk_up", flicker_gain_code_o, 16'h0004);
    flicker_sat_i <= 1'b1;
    @(posedge clk_sys_i); flicker_sat_i <= 1'b0;
    @(posedge clk_sys_i); #1 chk("flk_down", flicker_gain_code_o, 16'h0003);
    reg_write(8'hB1, 8'h80);
    flicker_low_i <= 1'b1;
    @(posedge clk_sys_i); flicker_low_i <= 1'b0;
    @(posedge clk_sys_i); #1 chk("flk_off", flicker_gain_code_o, 16'h0003);
    $display("test flicker gain done");
  endtask : t_flicker

  task automatic t_az();
    int n;
    do_reset();
    flicker_en_i <= 1'b1;
    az_run(n); chk("az_first", 16'(n), 16'(AZ_N));
    chk("irq_masked", {15'h0000, irq_o}, 16'h0000);
    reg_write(8'hE1, 8'h01);
    @(posedge clk_sys_i); #1 chk("irq_set", {15'h0000, irq_o}, 16'h0001);
    reg_read(8'hE0); chk("status_az", {8'h00, rd_val & 8'h01}, 16'h0001);
    @(posedge clk_sys_i); #1 chk("irq_clr", {15'h0000, irq_o}, 16'h0000);
    az_run(n); chk("az_once", 16'(n), 16'h0000);
    flicker_en_i <= 1'b0;
    do_reset();
    reg_write(8'hD6, 8'h01);
    az_run(n); chk("az_every1", 16'(n), 16'(AZ_N));
    az_run(n); chk("az_every2", 16'(n), 16'(AZ_N));
    do_reset();
    reg_write(8'hD6, 8'h00);
    az_run(n); chk("az_never", 16'(n), 16'h0000);
    $display("test auto zero done");
  endtask : t_az

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    do_reset();
    t_reset_vals();
    t_ident();
    t_rw();
    t_fifo();
    t_agc();
    t_ceiling();
    t_flicker();
    t_az();
    test_done();
  end
endmodule : tb_sacr_config_regs
